/* common/acr_defines.svh */
// Constants of the converter configuration and setup-pair registers
`ifndef ACR_DEFINES_SVH
`define ACR_DEFINES_SVH
`define ACR_CMD_WRITE_SETUP_PAIR 8'h05
`define ACR_CMD_READ_SETUP_PAIR  8'h0D
`define ACR_CMD_WRITE_CONFIG     8'h03
`define ACR_CMD_READ_CONFIG      8'h0B
`define ACR_CMD_SEL_MASK         8'h30
`define ACR_CMD_SEL_LSB          4
`define ACR_CMD_BASE_MASK        8'hCF
`define ACR_CFG_RESET            32'h00000000
`define ACR_PAIR_RESET           32'h00000000
`define ACR_BIT_DEPTH            31
`define ACR_BIT_SAVE             30
`define ACR_BIT_SYSRST           29
`define ACR_BIT_DONE             28
`define ACR_BIT_SHORT            27
`define ACR_BIT_GUARD            26
`define ACR_BIT_REFRNG           25
`define ACR_BIT_LAT_HI           24
`define ACR_BIT_LAT_LO           23
`define ACR_BIT_LSRC             22
`define ACR_BIT_CALSRC           20
`define ACR_BIT_RATE             19
`define ACR_CFG_WRITABLE         32'hFFD80000
`define ACR_CFG_DONE_MASK        32'h10000000
`define ACR_SU_CH_HI             15
`define ACR_SU_CH_LO             14
`define ACR_SU_LAT_HI            5
`define ACR_SU_LAT_LO            4
`define ACR_SU_PTR_HI            1
`define ACR_SU_PTR_LO            0
`define ACR_SU_DELAY             3
`define ACR_SU_RATE_HI           10
`define ACR_SU_RATE_LO           7
`define ACR_RATE_BASE_MHZ        4.9152
`define ACR_CLK_MHZ              100.0
`define ACR_DELAY_DEF            11'd1280
`define ACR_DELAY_SCALED         11'd1536
`endif

/* common/acr_pkg.sv */
// Types shared by the configuration register bank
package acr_pkg;
  typedef logic [31:0] acr_word_type;
  typedef logic [15:0] acr_setup_type;
  typedef logic [1:0]  acr_idx_type;
  typedef enum logic [1:0] {ACR_PWR_NORMAL, ACR_PWR_STANDBY, ACR_PWR_SLEEP} acr_pwr_type;
endpackage

/* common/acr_setup_if.sv */
// Active setup fields handed from the bank to the setup decoder
`timescale 1ns/10ps
`default_nettype none
interface acr_setup_if;
  acr_pkg::acr_setup_type setup;
  logic                   cal_source_select;
  logic                   rate_family_select;
  acr_pkg::acr_idx_type   channel;
  acr_pkg::acr_idx_type   cal_set;
  logic [1:0]             latch;
  logic [10:0]            delay_cycles;
  logic                   delay_enable;
  logic [3:0]             rate_code;
  modport bank (output setup, output cal_source_select, output rate_family_select,
                input channel, input cal_set, input latch, input delay_cycles,
                input delay_enable, input rate_code);
  modport dec  (input setup, input cal_source_select, input rate_family_select,
                output channel, output cal_set, output latch, output delay_cycles,
                output delay_enable, output rate_code);
endinterface
`default_nettype wire

/* rtl/acr_setup_decode.sv */
// Decoder of the setup chosen for conversion
`timescale 1ns/10ps
`default_nettype none
`include "acr_defines.svh"
module acr_setup_decode (
  acr_setup_if.dec su
);
  import acr_pkg::*;
  assign su.channel      = su.setup[`ACR_SU_CH_HI:`ACR_SU_CH_LO]; // RQ18
  // Pointer honoured only when the calibration source selects it
  assign su.cal_set      = su.cal_source_select ?
                           su.setup[`ACR_SU_PTR_HI:`ACR_SU_PTR_LO] :
                           su.setup[`ACR_SU_CH_HI:`ACR_SU_CH_LO]; // RQ4 RQ19
  assign su.latch        = su.setup[`ACR_SU_LAT_HI:`ACR_SU_LAT_LO];
  assign su.rate_code    = su.setup[`ACR_SU_RATE_HI:`ACR_SU_RATE_LO]; // RQ16
  assign su.delay_enable = su.setup[`ACR_SU_DELAY];
  assign su.delay_cycles = su.rate_family_select ? `ACR_DELAY_SCALED : `ACR_DELAY_DEF; // RQ5
endmodule
`default_nettype wire

/* rtl/acr_bank.sv */
// Configuration register and setup-pair register bank of the converter
// What this block does
// (RQ1) Latch-select clear: aux pins follow latch field of active setup.
// (RQ2) Latch-select set: aux pins load config bits 24:23 on command execution.
// (RQ3) Guard bit set: first aux pin carries common-mode, ignores latch select.
// (RQ4) Cal-source clear uses channel's registers; set uses setup pointer.
// (RQ5) Rate-family bit scales all word rates and filters by 5/6.
// (RQ6) Rates 7.5-3840 or 6.25-3200 Sps at 4.9152 MHz, scaling with clock.
// (RQ7) Depth bit: 0 standby keeps oscillator, 1 sleep stops it.
// (RQ8) Save bit: 0 normal, 1 enter chosen power-save mode.
// (RQ9) Writing 1 to system-reset bit starts internal reset; 0 is normal.
// (RQ10) Reset-done flag set after reset, cleared when configuration is read.
// (RQ11) Input-short bit disconnects and shorts all channel inputs.
// (RQ12) Controller sets reference-range bit by reference voltage magnitude.
// (RQ13) Four 32-bit setup-pair registers, first setup upper half.
// (RQ14) Controller always transfers both setups of a pair together.
// (RQ15) Command 05 writes one setup-pair register with 32-bit data.
// (RQ16) Setup holds channel, gain, rate, polarity, latch, delay, current, pointer.
// (RQ17) Setups are independent; a channel may appear in several.
// (RQ18) Channel field at 31:30 and 15:14, codes pick channels one-four.
// (RQ19) Pointer at 17:16 and 1:0 honoured only with cal-source set.
// (RQ20) Controller clears system-reset bit, then writes other bits separately.
// (RQ21) Controller writes zeros to unused configuration bits.
`timescale 1ns/10ps
`default_nettype none
`include "acr_defines.svh"
module acr_bank #(
  parameter int PAIRS = 4
) (
  input  wire logic                 clk_i,
  input  wire logic                 srst_i,
  input  wire logic                 cmd_valid_i,
  input  wire logic [7:0]           cmd_code_i,
  input  wire acr_pkg::acr_word_type cmd_data_i,
  input  wire logic [2:0]           active_setup_i,
  output logic                      rd_valid_o,
  output acr_pkg::acr_word_type     rd_data_o,
  output logic                      aux_out_first_o,
  output logic                      aux_out_second_o,
  output logic                      guard_active_o,
  output logic                      inputs_grounded_o,
  output logic                      ref_range_select_o,
  output acr_pkg::acr_pwr_type      power_mode_o,
  output logic                      logic_reset_o,
  output logic [1:0]                channel_o,
  output logic [1:0]                cal_set_o,
  output logic [3:0]                rate_code_o,
  output logic                      rate_family_select_o,
  output logic                      delay_enable_o,
  output logic [10:0]               delay_cycles_o
);
  import acr_pkg::*;

  acr_word_type cfg;
  acr_word_type pairs [PAIRS];
  logic         reset_done_flag;
  logic [1:0]   cfg_latch;
  acr_setup_if  su ();

  wire logic [7:0] base_cmd = cmd_code_i & `ACR_CMD_BASE_MASK;
  wire acr_idx_type sel_idx = acr_idx_type'((cmd_code_i & `ACR_CMD_SEL_MASK) >> `ACR_CMD_SEL_LSB);
  wire logic wr_cfg  = cmd_valid_i && (cmd_code_i == `ACR_CMD_WRITE_CONFIG);
  wire logic rd_cfg  = cmd_valid_i && (cmd_code_i == `ACR_CMD_READ_CONFIG);
  wire logic wr_pair = cmd_valid_i && (base_cmd == `ACR_CMD_WRITE_SETUP_PAIR);
  wire logic rd_pair = cmd_valid_i && (base_cmd == `ACR_CMD_READ_SETUP_PAIR);
  wire logic system_reset_bit = cfg[`ACR_BIT_SYSRST];

  // Upper half of a pair is the even-numbered (first) setup
  function automatic acr_setup_type pick_setup(input acr_word_type w, input logic lower);
    pick_setup = lower ? w[15:0] : w[31:16]; // RQ13
  endfunction

  assign su.setup = pick_setup(pairs[active_setup_i[2:1]], active_setup_i[0]); // RQ17
  assign su.cal_source_select  = cfg[`ACR_BIT_CALSRC];
  assign su.rate_family_select = cfg[`ACR_BIT_RATE];

  acr_setup_decode u_dec (
    .su (su)
  );

  // Configuration: while reset is held only the reset bit may change
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      cfg <= `ACR_CFG_RESET;
    end else if (wr_cfg) begin
      if (system_reset_bit || cmd_data_i[`ACR_BIT_SYSRST]) begin
        cfg <= `ACR_CFG_RESET; // RQ9 RQ20
        cfg[`ACR_BIT_SYSRST] <= cmd_data_i[`ACR_BIT_SYSRST];
      end else begin
        cfg <= cmd_data_i & `ACR_CFG_WRITABLE; // RQ21
      end
    end
  end

  // Setup pairs, cleared together with the internal logic
  always_ff @(posedge clk_i) begin
    if (srst_i || system_reset_bit) begin
      for (int i = 0; i < PAIRS; i++) begin
        pairs[i] <= `ACR_PAIR_RESET;
      end
    end else if (wr_pair) begin
      pairs[sel_idx] <= cmd_data_i; // RQ15 RQ14
    end
  end

  // Done flag: a new reset outranks a read in the same cycle
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      reset_done_flag <= 1'b1;
    end else if (system_reset_bit) begin
      reset_done_flag <= 1'b1; // RQ10
    end else if (rd_cfg) begin
      reset_done_flag <= 1'b0; // RQ10
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      logic_reset_o <= 1'b0;
    end else begin
      logic_reset_o <= system_reset_bit; // RQ9
    end
  end

  // Latch pins from configuration load only when a command executes;
  // a write that turns latch select on applies its own latch code at once
  always_ff @(posedge clk_i) begin
    if (srst_i || system_reset_bit) begin
      cfg_latch <= 2'b00;
    end else if (wr_cfg) begin
      if (cmd_data_i[`ACR_BIT_LSRC] && !cmd_data_i[`ACR_BIT_SYSRST]) begin
        cfg_latch <= cmd_data_i[`ACR_BIT_LAT_HI:`ACR_BIT_LAT_LO]; // RQ2
      end
    end else if (cmd_valid_i && cfg[`ACR_BIT_LSRC]) begin
      cfg_latch <= cfg[`ACR_BIT_LAT_HI:`ACR_BIT_LAT_LO]; // RQ2
    end
  end

  // Bit 0 of a latch code drives the second pin, bit 1 the first
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      aux_out_first_o  <= 1'b0;
      aux_out_second_o <= 1'b0;
      guard_active_o   <= 1'b0;
    end else begin
      guard_active_o <= cfg[`ACR_BIT_GUARD]; // RQ3
      if (cfg[`ACR_BIT_GUARD]) begin
        aux_out_first_o <= su.latch[1]; // RQ3
      end else if (cfg[`ACR_BIT_LSRC]) begin
        aux_out_first_o <= cfg_latch[1]; // RQ2
      end else begin
        aux_out_first_o <= su.latch[1]; // RQ1
      end
      aux_out_second_o <= cfg[`ACR_BIT_LSRC] ? cfg_latch[0] : su.latch[0]; // RQ1 RQ2
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      power_mode_o <= ACR_PWR_NORMAL;
    end else if (!cfg[`ACR_BIT_SAVE]) begin
      power_mode_o <= ACR_PWR_NORMAL; // RQ8
    end else if (cfg[`ACR_BIT_DEPTH]) begin
      power_mode_o <= ACR_PWR_SLEEP; // RQ7
    end else begin
      power_mode_o <= ACR_PWR_STANDBY; // RQ7
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      inputs_grounded_o    <= 1'b0;
      ref_range_select_o   <= 1'b0;
      channel_o            <= 2'b00;
      cal_set_o            <= 2'b00;
      rate_code_o          <= 4'h0;
      rate_family_select_o <= 1'b0;
      delay_enable_o       <= 1'b0;
      delay_cycles_o       <= `ACR_DELAY_DEF;
    end else begin
      inputs_grounded_o    <= cfg[`ACR_BIT_SHORT]; // RQ11
      ref_range_select_o   <= cfg[`ACR_BIT_REFRNG]; // RQ12
      channel_o            <= su.channel; // RQ18
      cal_set_o            <= su.cal_set; // RQ4 RQ19
      rate_code_o          <= su.rate_code; // RQ6
      rate_family_select_o <= cfg[`ACR_BIT_RATE]; // RQ5 RQ6
      delay_enable_o       <= su.delay_enable; // RQ16
      delay_cycles_o       <= su.delay_cycles;
    end
  end

  // Read answer one cycle after the command; done flag shows pre-read state
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      rd_valid_o <= 1'b0;
      rd_data_o  <= '0;
    end else begin
      rd_valid_o <= rd_cfg || rd_pair;
      if (rd_cfg) begin
        rd_data_o <= (cfg & ~`ACR_CFG_DONE_MASK) |
                     (reset_done_flag ? `ACR_CFG_DONE_MASK : 32'h00000000); // RQ10
      end else if (rd_pair) begin
        rd_data_o <= pairs[sel_idx]; // RQ13
      end
    end
  end

endmodule
`default_nettype wire

/* testbench/acr_bank_props.sv */
// Port checks for the register bank
`timescale 1ns/10ps
`default_nettype none
module acr_bank_props #(
  parameter int PAIRS = 4
) (
  input wire logic                  clk_i,
  input wire logic                  srst_i,
  input wire logic                  cmd_valid_i,
  input wire logic [7:0]            cmd_code_i,
  input wire acr_pkg::acr_word_type cmd_data_i,
  input wire logic                  rd_valid_o,
  input wire acr_pkg::acr_word_type rd_data_o,
  input wire logic                  aux_out_first_o,
  input wire logic                  aux_out_second_o,
  input wire logic                  guard_active_o,
  input wire logic                  inputs_grounded_o,
  input wire acr_pkg::acr_pwr_type  power_mode_o,
  input wire logic                  logic_reset_o
);
  import acr_pkg::*;
  logic cfg_wr;
  logic cfg_rd;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);
  assign cfg_wr = cmd_valid_i && cmd_code_i == 8'h03 && !logic_reset_o;
  assign cfg_rd = cmd_valid_i && cmd_code_i == 8'h0B;
  // Quiet gap after a write, so either output stage timing is settled
  sequence s_wr;
    cfg_wr ##1 !cmd_valid_i [*2];
  endsequence
  a_short_follow: assert property (
    s_wr |=> inputs_grounded_o == ($past(cmd_data_i[27], 3) && !$past(cmd_data_i[29], 3)))
    else $error("input short output wrong");
  a_guard_follow: assert property (
    s_wr |=> guard_active_o == ($past(cmd_data_i[26], 3) && !$past(cmd_data_i[29], 3)))
    else $error("guard output wrong");
  a_power_mode: assert property (
    s_wr |=> power_mode_o == ($past(cmd_data_i[30:29], 3) != 2'b10 ? ACR_PWR_NORMAL :
                              $past(cmd_data_i[31], 3) ? ACR_PWR_SLEEP : ACR_PWR_STANDBY))
    else $error("power mode wrong");
  a_sys_reset: assert property (
    s_wr |=> logic_reset_o == $past(cmd_data_i[29], 3))
    else $error("logic reset wrong");
  a_latch_cfg: assert property (
    s_wr |=> ($past(cmd_data_i[22], 3) && !$past(cmd_data_i[29], 3) && !$past(cmd_data_i[26], 3)
      |-> {aux_out_first_o, aux_out_second_o} == $past(cmd_data_i[24:23], 3)))
    else $error("latch pins wrong");
  a_rd_answer: assert property (
    cmd_valid_i && (cmd_code_i == 8'h0B || (cmd_code_i & 8'hCF) == 8'h0D) |=> rd_valid_o)
    else $error("read not answered");
  a_rd_cause: assert property (
    rd_valid_o |-> $past(cmd_valid_i))
    else $error("read answer without command");
  a_done_clear: assert property (
    cfg_rd ##1 (cfg_rd && !rd_data_o[29]) |=> !rd_data_o[28])
    else $error("done flag not cleared by read");
  c_cfg_write: cover property (s_wr);
  c_two_reads: cover property (cfg_rd ##1 cfg_rd);
  c_done_seen: cover property (rd_valid_o && rd_data_o[28]);
endmodule
bind acr_bank acr_bank_props #(.PAIRS(PAIRS)) acr_bank_props_inst (
  .clk_i, .srst_i, .cmd_valid_i, .cmd_code_i, .cmd_data_i, .rd_valid_o, .rd_data_o,
  .aux_out_first_o, .aux_out_second_o, .guard_active_o, .inputs_grounded_o,
  .power_mode_o, .logic_reset_o);
`default_nettype wire

/* testbench/acr_ctrl_model.sv */
// Controller model issuing commands to the register bank
`timescale 1ns/10ps
`default_nettype none
module acr_ctrl_model (
  input  wire logic                 clk_i,
  output var logic                  cmd_valid_o = 1'b0,
  output var logic [7:0]            cmd_code_o = 8'h00,
  output var acr_pkg::acr_word_type cmd_data_o = 32'h00000000,
  output var logic [2:0]            active_setup_o = 3'h0
);
  import acr_pkg::*;
  // Whole words only: both setups of a pair always travel together
  task automatic send(input logic [7:0] code, input acr_word_type data);
    @(posedge clk_i);
    cmd_valid_o <= 1'b1;
    cmd_code_o  <= code;
    cmd_data_o  <= (code == 8'h03) ? (data & 32'hFFD80000) : data;
  endtask
  // Released lines show the inverse so a stale value cannot pass
  task automatic idle();
    @(posedge clk_i);
    cmd_valid_o <= 1'b0;
    cmd_code_o  <= ~cmd_code_o;
    cmd_data_o  <= ~cmd_data_o;
  endtask
  task automatic pick(input logic [2:0] s);
    @(posedge clk_i);
    active_setup_o <= s;
  endtask
endmodule
`default_nettype wire

/* testbench/acr_bank_tb.sv */
// Self-checking bench for the register bank
`timescale 1ns/10ps
`default_nettype none
module acr_bank_tb;
  import acr_pkg::*;
  logic         clk_i = 1'b0;
  logic         srst_i = 1'b1;
  logic         cmd_valid_i;
  logic [7:0]   cmd_code_i;
  acr_word_type cmd_data_i;
  logic [2:0]   active_setup_i;
  logic         rd_valid_o;
  acr_word_type rd_data_o;
  logic         aux_out_first_o;
  logic         aux_out_second_o;
  logic         guard_active_o;
  logic         inputs_grounded_o;
  logic         ref_range_select_o;
  acr_pwr_type  power_mode_o;
  logic         logic_reset_o;
  logic [1:0]   channel_o;
  logic [1:0]   cal_set_o;
  logic [3:0]   rate_code_o;
  logic         rate_family_select_o;
  logic         delay_enable_o;
  logic [10:0]  delay_cycles_o;
  int           n_fail = 0;
  int           compares = 0;
  logic [1:0]   pw_d [4] = '{2'b00, 2'b01, 2'b11, 2'b10};
  acr_pwr_type  pw_e [4] = '{ACR_PWR_NORMAL, ACR_PWR_STANDBY, ACR_PWR_SLEEP, ACR_PWR_NORMAL};
  always #5 clk_i = ~clk_i;
  acr_ctrl_model acr_ctrl_model_inst (.clk_i, .cmd_valid_o(cmd_valid_i),
    .cmd_code_o(cmd_code_i), .cmd_data_o(cmd_data_i), .active_setup_o(active_setup_i));
  acr_bank #(.PAIRS(4)) acr_bank_inst (.clk_i, .srst_i, .cmd_valid_i, .cmd_code_i,
    .cmd_data_i, .active_setup_i, .rd_valid_o, .rd_data_o, .aux_out_first_o,
    .aux_out_second_o, .guard_active_o, .inputs_grounded_o, .ref_range_select_o,
    .power_mode_o, .logic_reset_o, .channel_o, .cal_set_o, .rate_code_o,
    .rate_family_select_o, .delay_enable_o, .delay_cycles_o);
  task automatic tally_and_finish();
    if (n_fail == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic cmp_w(input acr_word_type got, input acr_word_type exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_b(input logic [15:0] got, input logic [15:0] exp);
    cmp_w({16'h0000, got}, {16'h0000, exp});
  endtask
  // Settling wait covers the register plus output stage after a command
  task automatic wr(input logic [7:0] code, input acr_word_type data);
    acr_ctrl_model_inst.send(code, data);
    acr_ctrl_model_inst.idle();
    repeat (3) @(posedge clk_i);
    #1;
  endtask
  task automatic rd(input logic [7:0] code, input acr_word_type exp);
    int i;
    acr_ctrl_model_inst.send(code, 32'h00000000);
    acr_ctrl_model_inst.idle();
    #1;
    for (i = 0; i < 4 && rd_valid_o !== 1'b1; i++) begin
      @(posedge clk_i);
      #1;
    end
    if (rd_valid_o !== 1'b1) begin
      n_fail++;
      tally_and_finish();
    end
    cmp_w(rd_data_o, exp);
  endtask
  task automatic see(input logic [2:0] s, input logic [5:0] exp);
    acr_ctrl_model_inst.pick(s);
    repeat (3) @(posedge clk_i);
    #1;
    cmp_b(16'({aux_out_first_o, aux_out_second_o, channel_o, cal_set_o}), 16'(exp));
  endtask
  initial begin
    repeat (20000) @(posedge clk_i);
    n_fail++;
    tally_and_finish();
  end
  initial begin
    repeat (6) @(posedge clk_i);
    srst_i <= 1'b0;
    rd(8'h0B, 32'h10000000);
    rd(8'h0B, 32'h00000000);
    wr(8'h03, 32'h20000000);
    cmp_b(16'(logic_reset_o), 16'h0001);
    wr(8'h03, 32'h00000000);
    acr_ctrl_model_inst.send(8'h0B, 32'h00000000);
    acr_ctrl_model_inst.send(8'h0B, 32'h00000000);
    wr(8'h00, 32'h00000000);
    cmp_w(rd_data_o, 32'h00000000);
    wr(8'h03, 32'h0E000000);
    cmp_b(16'({inputs_grounded_o, guard_active_o, ref_range_select_o}), 16'h0007);
    rd(8'h0B, 32'h0E000000);
    for (int i = 0; i < 4; i++) begin
      wr(8'h03, {pw_d[i], 30'h0});
      cmp_b(16'(power_mode_o), 16'(pw_e[i]));
    end
    for (int n = 0; n < 4; n++)
      wr(8'(8'h05 | (n << 4)), {4{8'(8'h31 + n)}});
    for (int n = 0; n < 4; n++)
      rd(8'(8'h0D | (n << 4)), {4{8'(8'h31 + n)}});
    wr(8'h05, 32'h801B4020);
    see(3'd1, 6'b100101);
    see(3'd0, 6'b011010);
    cmp_b(16'({rate_family_select_o, delay_enable_o, delay_cycles_o}), 16'h0D00);
    wr(8'h03, 32'h00080000);
    cmp_b(16'({rate_family_select_o, delay_enable_o, delay_cycles_o}), 16'h1E00);
    wr(8'h03, 32'h00100000);
    see(3'd0, 6'b011011);
    see(3'd1, 6'b100100);
    wr(8'h03, 32'h00C00000);
    see(3'd1, 6'b010101);
    wr(8'h03, 32'h01400000);
    see(3'd0, 6'b101010);
    wr(8'h03, 32'h04C00000);
    see(3'd1, 6'b110101);
    wr(8'h15, 32'h05800000);
    see(3'd2, 6'b010000);
    cmp_b(16'(rate_code_o), 16'h000B);
    tally_and_finish();
  end
endmodule
`default_nettype wire
